// >>> rtl/scp_pkg.sv
// Contract
// - host frames each command with 02h ... 03h, digits as ASCII codes
// - 999999 outside a session enters programming mode, replies 06h
// - a frame holding a non-digit byte such as 3Ah is answered 15h
// - in programming mode 415870 selects 19200 baud and is answered 06h
// - an accepted baud change stays pending until the session exits
// - 999999 inside a session leaves it, answers 06h, sounds a long beep
// - no command for 20 seconds in a session gives 15h and drops it
// - factory line is 9600 baud, space parity, 2 stop, 7 data bits
package scp_pkg;
    localparam logic [7:0]  SCP_STX        = 8'h02;
    localparam logic [7:0]  SCP_ETX        = 8'h03;
    localparam logic [7:0]  SCP_ACK        = 8'h06;
    localparam logic [7:0]  SCP_NAK        = 8'h15;
    localparam logic [7:0]  SCP_DIGIT_LO   = 8'h30;
    localparam logic [7:0]  SCP_DIGIT_HI   = 8'h39;
    localparam int          SCP_DIGITS     = 6;
    localparam logic [23:0] SCP_CMD_PROG   = 24'h999999;
    localparam logic [23:0] SCP_CMD_B19200 = 24'h415870;
    localparam int          SCP_TIMEOUT_S  = 20;
    localparam int          SCP_CLK_HZ     = 200_000_000;
    localparam longint      SCP_TIMEOUT_CYC = longint'(SCP_TIMEOUT_S) * SCP_CLK_HZ;
    localparam int          SCP_BEEP_MS    = 500;
    localparam int          SCP_BEEP_CYC   = SCP_BEEP_MS * (SCP_CLK_HZ / 1000);
    // line setting codes
    localparam logic [1:0]  SCP_BAUD_9600  = 2'h0;
    localparam logic [1:0]  SCP_BAUD_19200 = 2'h1;
    localparam logic [1:0]  SCP_PAR_SPACE  = 2'h3;
    localparam logic [1:0]  SCP_STOP_TWO   = 2'h2;
    localparam logic [3:0]  SCP_DATA_SEVEN = 4'h7;

    typedef struct packed {
        logic [1:0] baud;
        logic [1:0] parity;
        logic [1:0] stop_bits;
        logic [3:0] data_bits;
    } scp_line_t;

    localparam scp_line_t SCP_LINE_DEFAULT = '{SCP_BAUD_9600, SCP_PAR_SPACE,
                                               SCP_STOP_TWO, SCP_DATA_SEVEN};

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } scp_byte_t;

    function automatic logic scp_is_digit(input logic [7:0] b);
        return (b >= SCP_DIGIT_LO) && (b <= SCP_DIGIT_HI);
    endfunction : scp_is_digit
endpackage : scp_pkg

// >>> rtl/scp_parser.sv
`timescale 1ns/1ps
`default_nettype none
module scp_parser #(
    parameter longint TIMEOUT_CYC = scp_pkg::SCP_TIMEOUT_CYC,
    parameter int     BEEP_CYC    = scp_pkg::SCP_BEEP_CYC
) (
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    input  wire scp_pkg::scp_byte_t rx_in,
    input  wire logic              tx_ready_in,
    output logic                   tx_valid_out,
    output logic [7:0]             tx_data_out,
    output scp_pkg::scp_line_t     line_out,
    output logic                   prog_mode_out,
    output logic                   long_beep_out
);
    import scp_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_BODY  = 3'b010,
        ST_REPLY = 3'b100
    } scp_state_t;

    scp_state_t  state_q;
    logic [23:0] cmd_q;
    logic [3:0]  count_q;
    logic        bad_q;
    logic        session_q;
    scp_line_t   line_q;
    logic        pend_q;
    logic [1:0]  pend_baud_q;
    logic [37:0] idle_q;
    logic [31:0] beep_q;
    logic [7:0]  tx_q;
    logic        tmo_nak;

    wire logic frame_end = state_q == ST_BODY && rx_in.valid && rx_in.data == SCP_ETX;
    wire logic frame_ok  = !bad_q && count_q != 4'h0;
    wire logic is_prog   = frame_ok && count_q == 4'(SCP_DIGITS) && cmd_q == SCP_CMD_PROG;
    wire logic is_baud   = frame_ok && count_q == 4'(SCP_DIGITS) && cmd_q == SCP_CMD_B19200;
    // outside a session only the enter command is meaningful
    wire logic accept    = frame_ok && (session_q || is_prog);
    // a second enter command inside a session closes it
    wire logic exit_cmd  = frame_end && is_prog && session_q;

    assign tmo_nak = session_q && state_q == ST_IDLE && idle_q >= 38'(TIMEOUT_CYC - 1);

    // frame collection; host sends nothing until the reply is out
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            cmd_q   <= 24'h0;
            count_q <= 4'h0;
            bad_q   <= 1'b0;
            tx_q    <= 8'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (tmo_nak) begin
                        tx_q    <= SCP_NAK;
                        state_q <= ST_REPLY;
                    end else if (rx_in.valid && rx_in.data == SCP_STX) begin
                        cmd_q   <= 24'h0;
                        count_q <= 4'h0;
                        bad_q   <= 1'b0;
                        state_q <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (frame_end) begin
                        tx_q    <= accept ? SCP_ACK : SCP_NAK;
                        state_q <= ST_REPLY;
                    end else if (rx_in.valid) begin
                        if (!scp_is_digit(rx_in.data)) begin
                            bad_q <= 1'b1;
                        end
                        if (count_q != 4'hF) begin
                            count_q <= count_q + 4'h1;
                        end
                        cmd_q <= {cmd_q[19:0], rx_in.data[3:0]};
                    end
                end
                ST_REPLY: begin
                    if (tx_ready_in) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign tx_valid_out = state_q == ST_REPLY;
    assign tx_data_out  = tx_q;

    // session state and pending line settings
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            session_q   <= 1'b0;
            line_q      <= SCP_LINE_DEFAULT;
            pend_q      <= 1'b0;
            pend_baud_q <= SCP_BAUD_9600;
        end else if (tmo_nak) begin
            session_q <= 1'b0;
            pend_q    <= 1'b0;
        end else if (frame_end) begin
            if (!accept) begin
                session_q <= 1'b0;
                pend_q    <= 1'b0;
            end else if (is_prog && session_q) begin
                session_q <= 1'b0;
                pend_q    <= 1'b0;
                if (pend_q) begin
                    line_q.baud <= pend_baud_q;
                end
            end else if (is_prog) begin
                session_q <= 1'b1;
            end else if (is_baud) begin
                pend_q      <= 1'b1;
                pend_baud_q <= SCP_BAUD_19200;
            end
        end
    end

    // inactivity timer restarts on every received byte
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_q <= 38'h0;
        end else if (!session_q || rx_in.valid || state_q != ST_IDLE) begin
            idle_q <= 38'h0;
        end else begin
            idle_q <= idle_q + 38'h1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            beep_q <= 32'h0;
        end else if (exit_cmd) begin
            beep_q <= 32'(BEEP_CYC);
        end else if (beep_q != 32'h0) begin
            beep_q <= beep_q - 32'h1;
        end
    end

    assign long_beep_out = beep_q != 32'h0;
    assign prog_mode_out = session_q;
    assign line_out      = line_q;

    // frame intake
    a_stx_opens: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_q == ST_IDLE && !tmo_nak && rx_in.valid && rx_in.data == SCP_STX
        |=> state_q == ST_BODY)
        else $error("start byte did not open a frame");

    // replies and session entry
    a_enter_ack: assert property (@(posedge core_clk_in) disable iff (rst_in)
        frame_end && is_prog && !session_q |=> session_q && tx_valid_out && tx_data_out == SCP_ACK)
        else $error("enter command not acknowledged");

    a_outside_nak: assert property (@(posedge core_clk_in) disable iff (rst_in)
        frame_end && !session_q && !is_prog
        |=> tx_valid_out && tx_data_out == SCP_NAK && !session_q)
        else $error("frame outside session not refused");

    a_bad_nak: assert property (@(posedge core_clk_in) disable iff (rst_in)
        frame_end && bad_q |=> tx_valid_out && tx_data_out == SCP_NAK && !session_q)
        else $error("invalid frame not refused");

    a_reply_codes: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tx_valid_out |-> tx_data_out == SCP_ACK || tx_data_out == SCP_NAK)
        else $error("reply byte not ack or nak");

    a_nak_drops: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(tx_valid_out) && tx_data_out == SCP_NAK |-> !session_q)
        else $error("session kept after nak");

    a_pend_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
        frame_end && !accept |=> !pend_q && !session_q)
        else $error("pending change kept after nak");

    // deferred line settings, exit beep and session timeout
    a_baud_held: assert property (@(posedge core_clk_in) disable iff (rst_in)
        session_q && $past(session_q) |-> $stable(line_out))
        else $error("line changed inside session");

    a_line_exit: assert property (@(posedge core_clk_in) disable iff (rst_in)
        exit_cmd && pend_q |=> line_out.baud == SCP_BAUD_19200)
        else $error("pending baud not applied on exit");

    a_baud_ack: assert property (@(posedge core_clk_in) disable iff (rst_in)
        frame_end && is_baud && session_q |=> pend_q && tx_data_out == SCP_ACK)
        else $error("baud command not held");

    a_exit_beep: assert property (@(posedge core_clk_in) disable iff (rst_in)
        exit_cmd |=> !session_q && long_beep_out && tx_data_out == SCP_ACK)
        else $error("exit without ack and beep");

    a_beep_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !long_beep_out && !exit_cmd |=> !long_beep_out)
        else $error("beep without session exit");

    a_timeout_nak: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tmo_nak |=> !session_q && tx_valid_out && tx_data_out == SCP_NAK)
        else $error("timeout not refused");

    a_idle_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !session_q |=> idle_q == 38'h0)
        else $error("timer running outside session");

    // reply handshake with the transmitter, and factory line after reset
    a_reply_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
        else $error("reply dropped before taken");

    a_reply_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tx_valid_out && tx_ready_in |=> !tx_valid_out)
        else $error("reply stood after being taken");

    a_default_line: assert property (@(posedge core_clk_in)
        $fell(rst_in) |-> line_out == SCP_LINE_DEFAULT)
        else $error("line not at factory default");

    c_enter: cover property (@(posedge core_clk_in) frame_end && is_prog && !session_q);
    c_baud: cover property (@(posedge core_clk_in) frame_end && is_baud && session_q);
    c_exit: cover property (@(posedge core_clk_in) frame_end && is_prog && session_q && pend_q);
    c_nak: cover property (@(posedge core_clk_in) frame_end && bad_q && session_q);
    c_timeout: cover property (@(posedge core_clk_in) tmo_nak);
endmodule : scp_parser
`default_nettype wire

// >>> test/scp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
    input  wire logic          clk_in,
    output scp_pkg::scp_byte_t rx_out,
    input  wire logic          tx_valid_in,
    input  wire logic [7:0]    tx_data_in,
    output logic               tx_ready_out
);
    import scp_pkg::*;
    initial begin
        rx_out = '0;
        tx_ready_out = 1'b0;
    end
    // random stall so the reply must stand until taken
    task automatic take_reply(input int limit, output logic [7:0] r, output bit ok);
        ok = 0;
        r = 'x;
        for (int i = 0; i < limit && !ok; i++) begin
            @(posedge clk_in);
            #1;
            ok = tx_valid_in;
        end
        if (ok) begin
            r = tx_data_in;
            repeat ($urandom_range(3, 0)) @(posedge clk_in);
            @(posedge clk_in) tx_ready_out <= 1'b1;
            @(posedge clk_in) tx_ready_out <= 1'b0;
            @(posedge clk_in);
        end
    endtask : take_reply
    task automatic send(input string s, output logic [7:0] r, output bit ok);
        @(posedge clk_in) rx_out <= '{1'b1, SCP_STX};
        foreach (s[i]) @(posedge clk_in) rx_out <= '{1'b1, s[i]};
        @(posedge clk_in) rx_out <= '{1'b1, SCP_ETX};
        // released line shows the inverse, not a stale byte
        @(posedge clk_in) rx_out <= '{1'b0, ~SCP_ETX};
        take_reply(64, r, ok);
    endtask : send
endmodule : scp_host_model
`default_nettype wire

// >>> test/serial_config_command_parser_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_config_command_parser_bench;
    import scp_pkg::*;
    localparam int TMO = 200;
    logic       core_clk_in, rst_in, tx_valid, tx_ready, prog, beep, ok;
    logic [7:0] tx_data, r;
    scp_byte_t  rx;
    scp_line_t  line;
    int miscompares = 0, samples_checked = 0;
    int m_prog = 0, m_baud = 0, m_pend = 0, m_beep = 0;
    logic [7:0] exp_q[$];
    scp_parser #(.TIMEOUT_CYC(TMO), .BEEP_CYC(40)) dut (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .rx_in(rx), .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
        .tx_data_out(tx_data), .line_out(line), .prog_mode_out(prog), .long_beep_out(beep));
    scp_host_model host (.clk_in(core_clk_in), .rx_out(rx), .tx_valid_in(tx_valid),
        .tx_data_in(tx_data), .tx_ready_out(tx_ready));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] ref_reply(input string s);
        bit dig;
        dig = s.len() > 0;
        m_beep = 0;
        foreach (s[i]) if (s[i] < "0" || s[i] > "9") dig = 0;
        if (!dig || (m_prog == 0 && s != "999999")) begin
            m_prog = 0;
            m_pend = m_baud;
            return SCP_NAK;
        end
        if (s == "415870") m_pend = SCP_BAUD_19200;
        if (s == "999999") begin
            if (m_prog != 0) m_baud = m_pend;
            m_beep = m_prog;
            m_pend = m_baud;
            m_prog = (m_prog == 0);
        end
        return SCP_ACK;
    endfunction : ref_reply
    task automatic after_reply(input logic [7:0] exp);
        #1;
        if (!ok) begin
            chk(16'h0000, 16'hFFFF, "no reply");
            give_verdict();
        end else begin
            chk(r, exp, "reply");
            chk(prog, m_prog[0], "session");
            chk(line.baud, m_baud[1:0], "baud");
            chk(beep, m_beep[0], "beep");
        end
    endtask : after_reply
    task automatic frame(input string s);
        exp_q.push_back(ref_reply(s));
        host.send(s, r, ok);
        after_reply(exp_q.pop_front());
    endtask : frame
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    initial begin
        void'($urandom(32'hC10B));
        rst_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        chk(line, SCP_LINE_DEFAULT, "line default");
        rst_in <= 1'b0;
        $display("test reset done");
        frame("999999");
        frame("99999:");
        frame("999998");
        $display("test reject done");
        frame("999999");
        repeat (3) frame($sformatf("%06d", $urandom_range(399999, 0)));
        frame("415870");
        frame("999999");
        repeat (20) @(posedge core_clk_in);
        #1;
        chk(beep, 1'b1, "beep held");
        repeat (30) @(posedge core_clk_in);
        #1;
        chk(beep, 1'b0, "beep length");
        $display("test baud done");
        frame("999999");
        exp_q.push_back(SCP_NAK);
        repeat (TMO - 10) @(posedge core_clk_in);
        #1;
        chk(tx_valid, 1'b0, "early timeout");
        chk(prog, 1'b1, "session before timeout");
        host.take_reply(64, r, ok);
        m_prog = 0;
        m_pend = m_baud;
        after_reply(exp_q.pop_front());
        $display("test timeout done");
        frame("999999");
        frame("");
        $display("test empty frame done");
        give_verdict();
    end
endmodule : serial_config_command_parser_bench
`default_nettype wire
